// ===== sup_pkg.sv
// Package with constants and carrier types for the supervisor control block.
package sup_pkg;

	localparam int CLK_MHZ = 100;
	localparam int REL_MS = 200;
	localparam int NV_MS = 10;
	localparam int REL_CYC = REL_MS * 1000 * CLK_MHZ;
	localparam int NV_CYC = NV_MS * 1000 * CLK_MHZ;
	localparam int DOG_1S_MS = 1000;
	localparam int DOG_450_MS = 450;
	localparam int DOG_150_MS = 150;
	localparam int DOG_1MIN_MS = 60000;
	localparam int DOG_20S_MS = 20000;
	localparam int DOG_10S_MS = 10000;
	localparam int DOG_5S_MS = 5000;

	localparam logic [15:0] CTRL_ADDR = 16'hffff;
	localparam logic [15:0] OTP1_BASE = 16'h0000;
	localparam logic [15:0] OTP2_BASE = 16'h0040;
	localparam logic [15:0] OTP_TOP = 16'h007f;
	localparam logic [15:0] ARRAY_TOP = 16'h1fff;
	localparam int OTP_BYTES = 64;
	localparam int HW_LOCK_BIT = 7;
	localparam int FLAG_BIT = 6;
	localparam int DOG_LSB = 3;
	localparam int GUARD_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] DOG_OFF = 3'h3;
	localparam logic [2:0] TAMPER_LIMIT = 3'h7;
	localparam logic [23:0] ID_BASE = 24'h5a5a5a; // Arbitrary value.

	typedef enum logic [2:0] {
		PW_MEM_READ = 3'h0,
		PW_MEM_WRITE = 3'h1,
		PW_OTP_READ = 3'h2,
		PW_OTP_WRITE = 3'h3,
		PW_NONE = 3'h4
	} pw_kind_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] data;
	} acc_req_t;

	typedef struct packed {
		logic hit;
		logic ok;
		logic [7:0] data;
	} acc_rsp_t;

endpackage

// ===== sup_dog.sv
// Watchdog timer with restart on serial start condition.
`timescale 1ns/1ps
module sup_dog #(
	parameter int CLK_MHZ = sup_pkg::CLK_MHZ,
	parameter int MS_DIV = 1000 * CLK_MHZ
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic restart,
	input wire logic [2:0] period,
	output logic expire
);
	logic [15:0] ms_limit;
	logic [31:0] pre_reg;
	logic [15:0] ms_reg;
	logic tick;

	if (MS_DIV < 1) begin
		$error("sup_dog: millisecond divider must be positive.");
	end

	always_comb begin
		case (period)
			3'h0: ms_limit = 16'(sup_pkg::DOG_1S_MS);
			3'h1: ms_limit = 16'(sup_pkg::DOG_450_MS);
			3'h2: ms_limit = 16'(sup_pkg::DOG_150_MS);
			3'h4: ms_limit = 16'(sup_pkg::DOG_1MIN_MS);
			3'h5: ms_limit = 16'(sup_pkg::DOG_20S_MS);
			3'h6: ms_limit = 16'(sup_pkg::DOG_10S_MS);
			3'h7: ms_limit = 16'(sup_pkg::DOG_5S_MS);
			default: ms_limit = 16'h0000;
		endcase
	end

	assign tick = (pre_reg == 32'(MS_DIV - 1));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_reg <= 32'h0;
			ms_reg <= 16'h0;
			expire <= 1'b0;
		end else if (restart || period == sup_pkg::DOG_OFF) begin
			pre_reg <= 32'h0;
			ms_reg <= 16'h0;
			expire <= 1'b0;
		end else begin
			pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
			expire <= 1'b0;
			if (tick) begin
				// A shorter period written mid-count must still expire.
				if (ms_reg >= ms_limit - 16'h1) begin
					ms_reg <= 16'h0;
					expire <= 1'b1;
				end else begin
					ms_reg <= ms_reg + 16'h1;
				end
			end
		end
	end

	property p_off_quiet;
		@(posedge clk) disable iff (!reset_n)
		(period == sup_pkg::DOG_OFF) |=> !expire;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("Watchdog fired while disabled.");

	property p_restart_quiet;
		@(posedge clk) disable iff (!reset_n)
		restart |=> !expire;
	endproperty
	a_restart_quiet: assert property (p_restart_quiet)
		else $error("Watchdog fired right after a restart.");
endmodule

// ===== sup_ctrl.sv
// Supervisor control: reset generation, watchdog, lock and password gating.
`timescale 1ns/1ps
// Summary of operation
// - Reset held while primary low; released after 200 ms good supply.
// - Reset asserted from power-up through the power-on interval.
// - Serial start restarts watchdog; expiry while enabled asserts reset.
// - Period codes 000, 001, 010 give 1 s, 450 ms, 150 ms.
// - Code 011 disables; 100..111 give 1 min, 20 s, 10 s, 5 s.
// - Period field nonvolatile; host changes it unless hardware lock applies.
// - Lock pin and lock bit high reject writes; else write password needed.
// - Protected array access at FFFFh reaches the control register.
// - Bit 7 lock, bit 6 flag, bits 5:3 period, bits 2:0 size.
// - Flag volatile: cleared on low supply, loaded by write, kept on watchdog.
// - Low supply aborts current command; running store completes.
// - Secondary fail output follows secondary monitor, released at once.
// - Two 64-byte OTP arrays, OTP read and write passwords.
// - OTP array one 0000h-003Fh, array two 0040h-007Fh.
// - OTP writes past 64 bytes wrap within the same array; here the index is taken straight from address bits 6:0.
// - Protected memory needs 64-bit read or write password first.
// - Protected region size comes from the three-bit select field.
// - Eighth invalid password sets permanent tamper bit in 32-bit ID.
// - Size 000 protects nothing, 111 all; 001 covers 0000h-003Fh.
// - Invalid passwords count; an entry taken while not busy, aborted or tampered starts a 10 ms busy cycle.
module sup_ctrl #(
	parameter int REL_CYC = sup_pkg::REL_CYC,
	parameter int NV_CYC = sup_pkg::NV_CYC,
	parameter int MS_DIV = 1000 * sup_pkg::CLK_MHZ,
	parameter logic [23:0] ID_BASE = sup_pkg::ID_BASE
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET_N,
	// Supply monitors, asynchronous comparator levels.
	input wire logic PRIMARY_OK,
	input wire logic SECONDARY_SUPPLY_SENSE,
	// Lock pin.
	input wire logic LOCK_PIN,
	// Events from and answers to the serial front end, same clock.
	input wire logic START_SEEN,
	input wire logic PW_ENTRY,
	input wire logic [2:0] PW_ENTRY_KIND,
	input wire logic [63:0] PW_ENTRY_VALUE,
	input wire logic STORE_BUSY,
	input sup_pkg::acc_req_t ACC_REQ,
	output sup_pkg::acc_rsp_t ACC_RSP,
	// Status toward the front end.
	output logic PW_BUSY,
	output logic ABORT,
	output logic [31:0] DEVICE_ID,
	output logic [7:0] OTP_INDEX,
	// Open-drain outputs, enable high while pulling low.
	output logic RESET_OUT_N,
	output logic RESET_OUT_OE,
	output logic SECONDARY_SUPPLY_FAIL_N,
	output logic SECONDARY_SUPPLY_FAIL_OE
);
	logic [1:0] prim_sync_reg;
	logic [1:0] sec_sync_reg;
	logic [1:0] lock_sync_reg;
	logic prim_ok;
	logic sec_ok;
	logic lock_in;
	logic [31:0] rel_reg;
	logic rst_act_reg;
	logic dog_exp;
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [63:0] pw_reg [4];
	logic [4:0] pw_ok_reg;
	logic [2:0] tamper_cnt_reg;
	logic tamper_reg;
	logic [31:0] nv_reg;
	logic pw_match;
	logic hw_lock;
	logic is_ctrl;
	logic is_otp;
	logic is_prot;
	logic [15:0] guard_top;
	logic acc_ok;
	logic wr_ctrl;
	logic [2:0] kind_need;
	logic wr_otp;
	logic [7:0] rd_data;
	logic [7:0] otp_mem [2 * sup_pkg::OTP_BYTES];

	if (REL_CYC < 1 || NV_CYC < 1 || MS_DIV < 1) begin
		$error("sup_ctrl: cycle counts must be at least one.");
	end

	// Two-stage synchronisers for asynchronous levels.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			prim_sync_reg <= 2'h0;
			sec_sync_reg <= 2'h0;
			lock_sync_reg <= 2'h0;
		end else begin
			prim_sync_reg <= {prim_sync_reg[0], PRIMARY_OK};
			sec_sync_reg <= {sec_sync_reg[0], SECONDARY_SUPPLY_SENSE};
			lock_sync_reg <= {lock_sync_reg[0], LOCK_PIN};
		end
	end
	assign prim_ok = prim_sync_reg[1];
	assign sec_ok = sec_sync_reg[1];
	assign lock_in = lock_sync_reg[1];

	// Reset pulse generation. The device reset itself stands for power-on.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_act_reg <= 1'b1;
			rel_reg <= 32'h0;
		end else if (!prim_ok) begin
			rst_act_reg <= 1'b1;
			rel_reg <= 32'h0;
		end else if (dog_exp) begin
			rst_act_reg <= 1'b1;
			rel_reg <= 32'h0;
		end else if (rst_act_reg) begin
			if (rel_reg == 32'(REL_CYC - 1)) begin
				rst_act_reg <= 1'b0;
				rel_reg <= 32'h0;
			end else begin
				rel_reg <= rel_reg + 32'h1;
			end
		end
	end
	assign RESET_OUT_N = ~rst_act_reg;
	assign RESET_OUT_OE = rst_act_reg;

	// Secondary fail follows the synchronised monitor directly.
	assign SECONDARY_SUPPLY_FAIL_N = sec_ok;
	assign SECONDARY_SUPPLY_FAIL_OE = ~sec_ok;

	// Commands are aborted while primary supply is low; stores continue.
	assign ABORT = ~prim_ok;

	// Watchdog held clear during reset so it restarts from zero afterwards.
	sup_dog #(
		.MS_DIV(MS_DIV)
	) u_dog (
		.clk(CLK),
		.reset_n(RESET_N),
		.restart(START_SEEN | rst_act_reg),
		.period(ctrl_reg[sup_pkg::DOG_LSB +: 3]),
		.expire(dog_exp)
	);

	// Password check and tamper counter. Grant bit 4 marks accesses that
	// need no password, so it is set whenever the grants are cleared.
	assign pw_match = (PW_ENTRY_KIND < 3'h4) &&
		(PW_ENTRY_VALUE == pw_reg[PW_ENTRY_KIND[1:0]]);

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pw_ok_reg <= 5'h10;
			tamper_cnt_reg <= 3'h0;
			tamper_reg <= 1'b0;
			nv_reg <= 32'h0;
		end else begin
			if (nv_reg != 32'h0)
				nv_reg <= nv_reg - 32'h1;
			if (ABORT)
				pw_ok_reg <= 5'h10;
			else if (PW_ENTRY && nv_reg == 32'h0 && !tamper_reg) begin
				nv_reg <= 32'(NV_CYC);
				pw_ok_reg <= 5'h10;
				if (pw_match)
					pw_ok_reg[PW_ENTRY_KIND] <= 1'b1;
				else if (tamper_cnt_reg == sup_pkg::TAMPER_LIMIT)
					tamper_reg <= 1'b1;
				else
					tamper_cnt_reg <= tamper_cnt_reg + 3'h1;
			end
		end
	end
	assign PW_BUSY = (nv_reg != 32'h0);
	assign DEVICE_ID = {ID_BASE, 7'h00, tamper_reg};

	// Passwords ship as zero; changing them is the front end's job.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < 4; i++)
				pw_reg[i] <= 64'h0;
		end else begin
			for (int i = 0; i < 4; i++)
				pw_reg[i] <= pw_reg[i];
		end
	end

	// Address classification.
	assign is_ctrl = ACC_REQ.addr == sup_pkg::CTRL_ADDR;
	assign is_otp = ACC_REQ.addr <= sup_pkg::OTP_TOP;

	always_comb begin
		case (ctrl_reg[sup_pkg::GUARD_LSB +: 3])
			3'h1: guard_top = 16'h003f;
			3'h2: guard_top = 16'h007f;
			3'h3: guard_top = 16'h00ff;
			3'h4: guard_top = 16'h01ff;
			3'h5: guard_top = 16'h07ff;
			3'h6: guard_top = 16'h0fff;
			3'h7: guard_top = sup_pkg::ARRAY_TOP;
			default: guard_top = 16'h0000;
		endcase
	end
	assign is_prot = (ctrl_reg[sup_pkg::GUARD_LSB +: 3] != 3'h0) &&
		(ACC_REQ.addr <= guard_top);

	// OTP index: address bit 6 picks the array, bits 5:0 the byte.
	assign OTP_INDEX = {1'b0, ACC_REQ.addr[6], ACC_REQ.addr[5:0]};

	// Pick the password the access needs. OTP is always guarded.
	always_comb begin
		if (is_otp && !is_ctrl)
			kind_need = ACC_REQ.write ? 3'(sup_pkg::PW_OTP_WRITE) :
				3'(sup_pkg::PW_OTP_READ);
		else if (is_ctrl || is_prot)
			kind_need = ACC_REQ.write ? 3'(sup_pkg::PW_MEM_WRITE) :
				3'(sup_pkg::PW_MEM_READ);
		else
			kind_need = 3'(sup_pkg::PW_NONE);
	end

	assign hw_lock = lock_in & ctrl_reg[sup_pkg::HW_LOCK_BIT];
	assign acc_ok = !ABORT && !PW_BUSY && pw_ok_reg[kind_need] &&
		!(is_ctrl && ACC_REQ.write && hw_lock);
	assign wr_ctrl = ACC_REQ.valid && ACC_REQ.write && is_ctrl && acc_ok;
	assign wr_otp = ACC_REQ.valid && ACC_REQ.write && is_otp && acc_ok;
	assign rd_data = !(ACC_REQ.valid && acc_ok) ? 8'h00 :
		is_ctrl ? ctrl_reg : is_otp ? otp_mem[OTP_INDEX[6:0]] : 8'h00;

	// One-time storage keeps no reset, as it outlives power-on.
	always_ff @(posedge CLK) begin
		if (wr_otp)
			otp_mem[OTP_INDEX[6:0]] <= ACC_REQ.data;
	end

	// Control register; flag clears on low supply, others kept.
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
			ctrl_next = ACC_REQ.data;
		if (!prim_ok)
			ctrl_next[sup_pkg::FLAG_BIT] = 1'b0;
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			ctrl_reg <= sup_pkg::CTRL_RESET;
		else
			ctrl_reg <= ctrl_next;
	end

	// Answer to the front end, registered.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			ACC_RSP <= '0;
		else begin
			ACC_RSP.hit <= ACC_REQ.valid && is_ctrl;
			ACC_RSP.ok <= ACC_REQ.valid && acc_ok;
			ACC_RSP.data <= rd_data;
		end
	end

	property p_low_holds;
		@(posedge CLK) disable iff (!RESET_N)
		!prim_ok |=> !RESET_OUT_N;
	endproperty
	a_low_holds: assert property (p_low_holds)
		else $error("Reset not asserted on low supply.");

	property p_dog_reset;
		@(posedge CLK) disable iff (!RESET_N)
		dog_exp |=> RESET_OUT_OE;
	endproperty
	a_dog_reset: assert property (p_dog_reset)
		else $error("Watchdog expiry did not assert reset.");

	property p_flag_clear;
		@(posedge CLK) disable iff (!RESET_N)
		!prim_ok |=> !ctrl_reg[sup_pkg::FLAG_BIT];
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("Flag not cleared on low supply.");

	property p_flag_dog;
		@(posedge CLK) disable iff (!RESET_N)
		(dog_exp && prim_ok && !wr_ctrl) |=>
			$stable(ctrl_reg[sup_pkg::FLAG_BIT]);
	endproperty
	a_flag_dog: assert property (p_flag_dog)
		else $error("Watchdog reset changed the flag.");

	property p_lock_rejects;
		@(posedge CLK) disable iff (!RESET_N)
		(hw_lock && prim_ok) |=> ctrl_reg == $past(ctrl_reg) ||
			!$past(prim_ok);
	endproperty
	a_lock_rejects: assert property (p_lock_rejects)
		else $error("Locked control register changed.");

	property p_sec_fail;
		@(posedge CLK) disable iff (!RESET_N)
		!sec_ok |-> !SECONDARY_SUPPLY_FAIL_N && SECONDARY_SUPPLY_FAIL_OE;
	endproperty
	a_sec_fail: assert property (p_sec_fail)
		else $error("Secondary fail output not asserted.");

	property p_tamper_sticky;
		@(posedge CLK) disable iff (!RESET_N)
		tamper_reg |=> tamper_reg;
	endproperty
	a_tamper_sticky: assert property (p_tamper_sticky)
		else $error("Tamper bit cleared.");

	property p_nv_busy;
		@(posedge CLK) disable iff (!RESET_N)
		(PW_ENTRY && !PW_BUSY && !ABORT && !tamper_reg) |=> PW_BUSY;
	endproperty
	a_nv_busy: assert property (p_nv_busy)
		else $error("Password entry did not start busy cycle.");

	property p_abort;
		@(posedge CLK) disable iff (!RESET_N)
		ABORT |=> !ACC_RSP.ok;
	endproperty
	a_abort: assert property (p_abort)
		else $error("Access granted during low supply.");

	property p_write_needs_pw;
		@(posedge CLK) disable iff (!RESET_N)
		(ACC_REQ.valid && ACC_REQ.write && is_ctrl && prim_ok &&
			!pw_ok_reg[sup_pkg::PW_MEM_WRITE]) |=> $stable(ctrl_reg);
	endproperty
	a_write_needs_pw: assert property (p_write_needs_pw)
		else $error("Control register written without password.");

	sequence s_entry_taken;
		PW_ENTRY && !PW_BUSY && !ABORT && !tamper_reg;
	endsequence

	property p_eighth_bad;
		@(posedge CLK) disable iff (!RESET_N)
		s_entry_taken ##0 (!pw_match &&
			tamper_cnt_reg == sup_pkg::TAMPER_LIMIT) |=> tamper_reg;
	endproperty
	a_eighth_bad: assert property (p_eighth_bad)
		else $error("Eighth invalid password did not set tamper bit.");

	property p_release_count;
		@(posedge CLK) disable iff (!RESET_N)
		$fell(rst_act_reg) |-> $past(rel_reg) == 32'(REL_CYC - 1);
	endproperty
	a_release_count: assert property (p_release_count)
		else $error("Reset released before the full interval.");
endmodule

// ===== host_model.sv
// Host model that sends serial start conditions at a fixed spacing.
`timescale 1ns/1ps
module host_model (
	// Clock and control.
	input wire logic clk,
	input wire logic run,
	input wire logic [15:0] gap,
	// Start condition event toward the supervisor.
	output logic start
);
	logic [15:0] cnt_reg;

	initial begin
		cnt_reg = 16'h0;
		start = 1'h0;
	end

	// The spacing is chosen by the bench to stay inside the watchdog period.
	always @(negedge clk) begin
		if (!run || cnt_reg == gap) cnt_reg <= 16'h0;
		else cnt_reg <= cnt_reg + 16'h1;
		start <= run && cnt_reg == gap;
	end
endmodule

// ===== supervisor_watchdog_control_tb.sv
// Self-checking testbench for the supervisor control block.
`timescale 1ns/1ps
module supervisor_watchdog_control_tb;
	localparam int REL = 20;
	localparam int NV = 5;
	localparam int DIV = 2;
	localparam logic [2:0] CODE [6] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h6, 3'h5};
	localparam int MS [6] = '{1000, 450, 150, 5000, 10000, 20000};
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic primary_ok = 1'h1;
	logic sense = 1'h1;
	logic lock = 1'h0;
	logic kick_pulse = 1'h0;
	logic pw_entry = 1'h0;
	logic [2:0] pw_kind = 3'h0;
	logic [63:0] pw_value = 64'h0;
	logic run = 1'h1;
	logic [15:0] gap = 16'h64;
	logic host_start;
	wire start_seen = kick_pulse | host_start;
	sup_pkg::acc_req_t acc_req = '0;
	sup_pkg::acc_rsp_t acc_rsp;
	logic pw_busy;
	logic abort;
	logic [31:0] dev_id;
	logic [7:0] otp_idx;
	logic rst_n;
	logic rst_oe;
	logic fail_n;
	logic fail_oe;
	int num_errors = 0;
	int comparisons = 0;

	always #5 clk = ~clk;

	host_model i_host (.clk(clk), .run(run), .gap(gap), .start(host_start));

	sup_ctrl #(.REL_CYC(REL), .NV_CYC(NV), .MS_DIV(DIV)) i_dut (
		.CLK(clk), .RESET_N(reset_n), .PRIMARY_OK(primary_ok),
		.SECONDARY_SUPPLY_SENSE(sense), .LOCK_PIN(lock),
		.START_SEEN(start_seen), .PW_ENTRY(pw_entry),
		.PW_ENTRY_KIND(pw_kind), .PW_ENTRY_VALUE(pw_value),
		.STORE_BUSY(1'h0), .ACC_REQ(acc_req), .ACC_RSP(acc_rsp),
		.PW_BUSY(pw_busy), .ABORT(abort), .DEVICE_ID(dev_id),
		.OTP_INDEX(otp_idx), .RESET_OUT_N(rst_n), .RESET_OUT_OE(rst_oe),
		.SECONDARY_SUPPLY_FAIL_N(fail_n),
		.SECONDARY_SUPPLY_FAIL_OE(fail_oe));

	task summarize;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task stall(input string what);
		num_errors++;
		$display("[FAIL] %s expected done seen timeout", what);
		summarize;
	endtask

	task pw(input logic [2:0] kind, input logic [63:0] val);
		int i;
		@(negedge clk);
		pw_entry = 1'h1;
		pw_kind = kind;
		pw_value = val;
		@(negedge clk);
		pw_entry = 1'h0;
		check("pw_busy", pw_busy, 1);
		for (i = 0; i < 50 && pw_busy !== 1'h0; i++) @(negedge clk);
		if (i == 50) stall("pw_busy");
	endtask

	// One request stands for exactly one cycle; the answer follows next cycle.
	task xfer(input logic [2:0] kind, input logic wr, input logic [15:0] a,
		input logic [7:0] d, input logic ok);
		pw(kind, 64'h0);
		@(negedge clk);
		acc_req = '{1'h1, wr, a, d};
		@(negedge clk);
		acc_req.valid = 1'h0;
		check("acc_ok", acc_rsp.ok, ok);
		check("acc_hit", acc_rsp.hit, a == 16'hffff);
		if (!wr && ok) check("acc_data", acc_rsp.data, d);
	endtask

	task wait_rst(input logic lv, input int bound, output int n);
		for (n = 0; n < bound && rst_n !== lv; n++) @(negedge clk);
		if (n == bound) stall("reset_out_n");
	endtask

	task kick;
		@(negedge clk);
		kick_pulse = 1'h1;
		@(negedge clk);
		kick_pulse = 1'h0;
	endtask

	task stay_high(input int cyc, input string what);
		int k;
		int low;
		low = 0;
		for (k = 0; k < cyc; k++) begin
			@(negedge clk);
			if (rst_n !== 1'h1) low++;
		end
		check(what, low, 0);
	endtask

	initial begin
		int n;
		int i;
		repeat (10) @(negedge clk);
		check("rst_in_reset", {rst_n, rst_oe}, 2'h1);
		reset_n = 1'h1;
		wait_rst(1'h1, REL + 10, n);
		check("por_release", n >= REL && n <= REL + 5, 1);
		$display("test power_on done");

		sense = 1'h0;
		repeat (4) @(negedge clk);
		check("v2_fail", {fail_n, fail_oe}, 2'h1);
		sense = 1'h1;
		repeat (4) @(negedge clk);
		check("v2_fail", {fail_n, fail_oe}, 2'h2);
		$display("test secondary done");

		@(negedge clk);
		acc_req = '{1'h1, 1'h1, 16'hffff, 8'h28};
		@(negedge clk);
		acc_req.valid = 1'h0;
		check("no_pw_write", acc_rsp.ok, 0);
		xfer(sup_pkg::PW_MEM_READ, 1'h0, 16'hffff, 8'h00, 1'h1);
		xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'hffff, 8'h68, 1'h1);
		xfer(sup_pkg::PW_MEM_READ, 1'h0, 16'hffff, 8'h68, 1'h1);
		primary_ok = 1'h0;
		repeat (4) @(negedge clk);
		check("abort", {abort, rst_n}, 2'h2);
		primary_ok = 1'h1;
		wait_rst(1'h1, REL + 10, n);
		check("low_release", n >= REL && n <= REL + 5, 1);
		xfer(sup_pkg::PW_MEM_READ, 1'h0, 16'hffff, 8'h28, 1'h1);
		$display("test control done");

		xfer(sup_pkg::PW_OTP_WRITE, 1'h1, 16'h0041, 8'ha5, 1'h1);
		check("otp_index", otp_idx, 8'h41);
		xfer(sup_pkg::PW_OTP_READ, 1'h0, 16'h0041, 8'ha5, 1'h1);
		xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'h0002, 8'h5a, 1'h0);
		$display("test otp done");

		xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'hffff, 8'h10, 1'h1);
		gap = 16'hc8;
		stay_high(1500, "kicked_dog");
		run = 1'h0;
		for (i = 0; i < 6; i++) begin
			xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'hffff,
				{2'h1, CODE[i], 3'h0}, 1'h1);
			kick;
			wait_rst(1'h0, 45000, n);
			check("dog_time", n >= MS[i] * DIV - 3 &&
				n <= MS[i] * DIV + 4, 1);
			wait_rst(1'h1, REL + 10, n);
			check("dog_hold", n >= REL - 1 && n <= REL + 3, 1);
		end
		xfer(sup_pkg::PW_MEM_READ, 1'h0, 16'hffff, 8'h68, 1'h1);
		xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'hffff, 8'h18, 1'h1);
		kick;
		stay_high(2500, "dog_off");
		$display("test watchdog done");

		lock = 1'h1;
		xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'hffff, 8'h98, 1'h1);
		xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'hffff, 8'h10, 1'h0);
		xfer(sup_pkg::PW_MEM_READ, 1'h0, 16'hffff, 8'h98, 1'h1);
		lock = 1'h0;
		xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'hffff, 8'h18, 1'h1);
		xfer(sup_pkg::PW_OTP_READ, 1'h0, 16'h0080, 8'h00, 1'h1);
		xfer(sup_pkg::PW_MEM_WRITE, 1'h1, 16'hffff, 8'h1b, 1'h1);
		xfer(sup_pkg::PW_OTP_READ, 1'h0, 16'h0080, 8'h00, 1'h0);
		xfer(sup_pkg::PW_MEM_READ, 1'h0, 16'h0080, 8'h00, 1'h1);
		$display("test lock done");

		for (i = 0; i < 8; i++) begin
			check("tamper", dev_id[0], 0);
			pw(sup_pkg::PW_MEM_READ, 64'h1);
		end
		check("tamper", dev_id, {sup_pkg::ID_BASE, 8'h01});
		$display("test tamper done");
		summarize;
	end
endmodule
